// ===== cpu_exception_sequencer.sv
// Exception-processing sequencer: status save, vector, stack frame, vector fetch
// Summary of operation
// - External: interrupt, bus error, reset; others internal
// - Trap, check, divide instructions raise exceptions
// - Trace acts as very high priority interrupt
// - Illegal, odd fetch, privilege violation raise exceptions
// - Four ordered steps per exception other than reset
// - Copy status first, then set supervisor, clear trace
// - Reset and interrupt update priority mask
// - Vector from acknowledge, co-processor, or internal
// - Frame size from type and execution point
// - Interrupt with master bit: short master-stack frame
// - Reset clears master bit, reads reset vector
// - Master stack for tasks, interrupt stack otherwise
// - Vector address is base plus number times four
// - Load new program counter, resume execution
// - Co-processor exception response is acknowledged, processed
// - Co-processor privilege check fails in user state
`timescale 1ns/1ps
module cpu_exception_sequencer (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   reset_req,
    input  wire logic                   bus_err,
    input  wire logic                   addr_err,
    input  wire logic                   odd_fetch,
    input  wire logic                   illegal_instr,
    input  wire logic                   priv_instr,
    input  wire logic                   breakpoint,
    input  wire logic                   trace_pend,
    input  wire logic [2:0]             irq_level,
    input  wire logic                   instr_exc,
    input  exc_pkg::instr_src_t         instr_src,
    input  wire logic [3:0]             sw_trap_num,
    input  wire logic                   coproc_exc,
    input  wire logic [7:0]             coproc_vector,
    input  wire logic                   coproc_priv_chk,
    input  wire logic                   mid_instr,
    input  wire logic [15:0]            sr_in,
    input  wire logic [31:0]            vector_base_pointer,
    input  wire logic                   iack_done,
    input  wire logic [7:0]             iack_vector,
    input  wire logic                   stack_done,
    input  wire logic                   fetch_done,
    input  wire logic [31:0]            fetch_data,
    output logic                        busy,
    output logic [15:0]                 sr_out,
    output logic [15:0]                 sr_saved,
    output logic                        iack_req,
    output logic [2:0]                  iack_level,
    output logic                        coproc_ack,
    output logic                        stack_req,
    output logic                        stack_master,
    output logic                        stack_short_master,
    output logic [3:0]                  frame_format,
    output logic [5:0]                  frame_words,
    output logic [7:0]                  vector_num,
    output logic                        fetch_req,
    output logic [31:0]                 vector_addr,
    output logic [31:0]                 new_pc,
    output logic                        resume,
    output logic                        external_cause
);
    import exc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        seq_state_t  st;
        exc_class_t  cls;
        logic [15:0] sr;
        logic [15:0] saved;
        logic [7:0]  vec;
        logic [2:0]  lvl;
        logic        iack;
        logic        cpack;
        logic        sreq;
        logic        smaster;
        logic        sshort;
        logic        short_done;
        logic [3:0]  fmt;
        logic [5:0]  words;
        logic        freq;
        logic [31:0] vaddr;
        logic [31:0] pc;
        logic        resume;
        logic        ext;
    } seq_t;

    seq_t cur_ff;
    seq_t nxt_ff;

    exc_class_t  winner;
    logic        priv_any;
    logic        irq_pend;
    logic [3:0]  fr_fmt;
    logic [5:0]  fr_words;
    logic [7:0]  int_vec;

    // ------------------------------------------------------------
    // Cause collection
    // ------------------------------------------------------------
    assign priv_any = priv_instr | (coproc_priv_chk & ~sr_in[SR_SUPER_BIT]);
    // Level seven is taken whatever the mask holds
    assign irq_pend = (irq_level == IPL_RESET_MASK) ||
                      (irq_level > sr_in[SR_IPL_LSB +: 3]);

    // ------------------------------------------------------------
    // Priority and frame selection
    // ------------------------------------------------------------
    exc_prio u_prio (
        .reset_req  (reset_req),
        .bus_err    (bus_err),
        .addr_err   (addr_err | odd_fetch),
        .trace_pend (trace_pend),
        .irq_pend   (irq_pend),
        .coproc_exc (coproc_exc),
        .priv_viol  (priv_any),
        .illegal    (illegal_instr),
        .instr_exc  (instr_exc),
        .breakpoint (breakpoint),
        .winner     (winner)
    );

    exc_frame u_frame (
        .cls       (cur_ff.cls),
        .mid_instr (mid_instr),
        .fmt       (fr_fmt),
        .words     (fr_words)
    );

    // ------------------------------------------------------------
    // Internal vector table
    // ------------------------------------------------------------
    always_comb begin
        int_vec = VEC_ILLEGAL;
        case (cur_ff.cls)
            EXC_RESET:     int_vec = VEC_RESET;
            EXC_BUS_ERR:   int_vec = VEC_BUS_ERR;
            EXC_ADDR_ERR:  int_vec = VEC_ADDR_ERR;
            EXC_TRACE:     int_vec = VEC_TRACE;
            EXC_PRIVILEGE: int_vec = VEC_PRIVILEGE;
            EXC_BREAKPT:   int_vec = VEC_BREAKPOINT;
            EXC_INSTR: begin
                case (instr_src)
                    INS_SW_TRAP:  int_vec = VEC_SW_BASE + {4'h0, sw_trap_num};
                    INS_DIVIDE:   int_vec = VEC_DIVIDE;
                    INS_BOUNDS,
                    INS_RANGE:    int_vec = VEC_BOUNDS;
                    default:      int_vec = VEC_CONDTRAP;
                endcase
            end
            default:       int_vec = VEC_ILLEGAL;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_ff        = cur_ff;
        // Pulses last one cycle unless set again
        nxt_ff.cpack  = 1'b0;
        nxt_ff.resume = 1'b0;
        case (cur_ff.st)
            ST_IDLE: begin
                // Causes are looked at only while idle
                if (winner != EXC_NONE) begin
                    nxt_ff.cls   = winner;
                    nxt_ff.lvl   = (winner == EXC_RESET) ? IPL_RESET_MASK : irq_level;
                    nxt_ff.ext   = (winner == EXC_RESET) || (winner == EXC_BUS_ERR) ||
                                   (winner == EXC_INTERRUPT);
                    nxt_ff.cpack = (winner == EXC_COPROC);
                    nxt_ff.saved = sr_in;
                    nxt_ff.sr    = sr_in;
                    nxt_ff.st    = ST_STATUS;
                end
            end

            ST_STATUS: begin
                // Modify only the copy taken on entry
                nxt_ff.sr[SR_SUPER_BIT]    = 1'b1;
                nxt_ff.sr[SR_TRACE_HI_BIT] = 1'b0;
                nxt_ff.sr[SR_TRACE_LO_BIT] = 1'b0;
                if (cur_ff.cls == EXC_RESET || cur_ff.cls == EXC_INTERRUPT) begin
                    nxt_ff.sr[SR_IPL_LSB +: 3] = cur_ff.lvl;
                end
                if (cur_ff.cls == EXC_RESET) begin
                    nxt_ff.sr[SR_MASTER_BIT] = 1'b0;
                end
                if (cur_ff.cls == EXC_INTERRUPT) begin
                    nxt_ff.iack = 1'b1;
                end
                nxt_ff.st = ST_VECTOR;
            end

            ST_VECTOR: begin
                if (cur_ff.cls == EXC_INTERRUPT) begin
                    if (iack_done) begin
                        nxt_ff.iack = 1'b0;
                        nxt_ff.vec  = iack_vector;
                        nxt_ff.st   = ST_STACK;
                    end
                end else begin
                    nxt_ff.vec = (cur_ff.cls == EXC_COPROC) ? coproc_vector : int_vec;
                    // Reset builds no frame and goes to the vector fetch
                    nxt_ff.st  = (cur_ff.cls == EXC_RESET) ? ST_FETCH : ST_STACK;
                end
                nxt_ff.short_done = 1'b0;
            end

            ST_STACK: begin
                // Interrupt on master stack: marker frame there first
                if (!cur_ff.sreq) begin
                    nxt_ff.sreq = 1'b1;
                    if (cur_ff.cls == EXC_INTERRUPT && cur_ff.sr[SR_MASTER_BIT] &&
                        !cur_ff.short_done) begin
                        nxt_ff.smaster = 1'b1;
                        nxt_ff.sshort  = 1'b1;
                        nxt_ff.fmt     = FMT_THROWAWAY;
                        nxt_ff.words   = WORDS_THROWAWAY;
                    end else begin
                        nxt_ff.smaster = cur_ff.sr[SR_MASTER_BIT];
                        nxt_ff.sshort  = 1'b0;
                        nxt_ff.fmt     = fr_fmt;
                        nxt_ff.words   = fr_words;
                    end
                end else if (stack_done) begin
                    nxt_ff.sreq = 1'b0;
                    if (cur_ff.sshort) begin
                        nxt_ff.sr[SR_MASTER_BIT] = 1'b0;
                        nxt_ff.short_done        = 1'b1;
                    end else begin
                        nxt_ff.st = ST_FETCH;
                    end
                end
            end

            ST_FETCH: begin
                // Address and request are registered on the same edge
                nxt_ff.vaddr = vector_base_pointer + (32'(cur_ff.vec) << VEC_SHIFT);
                nxt_ff.freq  = 1'b1;
                if (cur_ff.freq && fetch_done) begin
                    nxt_ff.freq = 1'b0;
                    nxt_ff.pc   = fetch_data;
                    nxt_ff.st   = ST_RESUME;
                end
            end

            ST_RESUME: begin
                // Idle on the next edge; a new cause may be taken on the edge after
                nxt_ff.resume = 1'b1;
                nxt_ff.st     = ST_IDLE;
            end

            default: begin
                nxt_ff.st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // All cleared, then the named fields take reset values
            cur_ff       <= '0;
            cur_ff.st    <= ST_IDLE;
            cur_ff.cls   <= EXC_NONE;
            cur_ff.sr    <= SR_RESET_VALUE;
            cur_ff.saved <= SR_RESET_VALUE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy               = (cur_ff.st != ST_IDLE);
    assign sr_out             = cur_ff.sr;
    assign sr_saved           = cur_ff.saved;
    assign iack_req           = cur_ff.iack;
    assign iack_level         = cur_ff.lvl;
    assign coproc_ack         = cur_ff.cpack;
    assign stack_req          = cur_ff.sreq;
    assign stack_master       = cur_ff.smaster;
    assign stack_short_master = cur_ff.sshort;
    assign frame_format       = cur_ff.fmt;
    assign frame_words        = cur_ff.words;
    assign vector_num         = cur_ff.vec;
    assign fetch_req          = cur_ff.freq;
    assign vector_addr        = cur_ff.vaddr;
    assign new_pc             = cur_ff.pc;
    assign resume             = cur_ff.resume;
    assign external_cause     = cur_ff.ext;
endmodule

// ===== cpu_exception_sequencer_assertions.sv
// Concurrent checks on the exception sequencer ports
`timescale 1ns/1ps
module cpu_exception_sequencer_assertions (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        reset_req,
    input wire logic        bus_err,
    input wire logic        addr_err,
    input wire logic        odd_fetch,
    input wire logic        trace_pend,
    input wire logic        coproc_exc,
    input wire logic        iack_done,
    input wire logic        fetch_done,
    input wire logic        busy,
    input wire logic        iack_req,
    input wire logic        coproc_ack,
    input wire logic        stack_req,
    input wire logic        stack_master,
    input wire logic        stack_short_master,
    input wire logic        fetch_req,
    input wire logic        resume,
    input wire logic [2:0]  irq_level,
    input wire logic [2:0]  iack_level,
    input wire logic [3:0]  frame_format,
    input wire logic [5:0]  frame_words,
    input wire logic [7:0]  iack_vector,
    input wire logic [7:0]  vector_num,
    input wire logic [15:0] sr_in,
    input wire logic [15:0] sr_out,
    input wire logic [15:0] sr_saved,
    input wire logic [31:0] vector_base_pointer,
    input wire logic [31:0] fetch_data,
    input wire logic [31:0] vector_addr,
    input wire logic [31:0] new_pc
);
    import exc_pkg::*;
    logic hi;
    assign hi = reset_req | bus_err | addr_err | odd_fetch | trace_pend | irq_level == 3'h7
        | irq_level > sr_in[10:8];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Sequence checks
    // ------------------------------------------------------------
    entry_busy_a: assert property (!busy && hi |=> busy)
        else $error("cause not taken");
    status_copy_a: assert property ($rose(busy) |-> sr_saved == $past(sr_in))
        else $error("status copy wrong");
    status_mod_a: assert property ($rose(busy) |=> sr_out[13] && sr_out[15:14] == 2'h0)
        else $error("status bits not changed");
    mask_level_a: assert property ($rose(iack_req) |-> sr_out[10:8] == iack_level)
        else $error("mask not level");
    reset_mask_a: assert property (!busy && reset_req |-> ##2 !sr_out[12] && sr_out[10:8] == IPL_RESET_MASK)
        else $error("reset status wrong");
    iack_vec_a: assert property (iack_req && iack_done |=> vector_num == $past(iack_vector) && !iack_req)
        else $error("acknowledge vector wrong");
    coproc_ack_a: assert property (!busy && coproc_exc && !hi |=> coproc_ack ##1 !coproc_ack)
        else $error("coproc ack missing");
    short_frame_a: assert property (stack_req && stack_short_master |-> stack_master && sr_saved[12]
        && frame_format == FMT_THROWAWAY && frame_words == WORDS_THROWAWAY)
        else $error("short frame wrong");
    stack_sel_a: assert property (stack_req |-> stack_master == (sr_out[12] | stack_short_master))
        else $error("stack select wrong");
    fmt_size_a: assert property (stack_req |-> frame_words == (frame_format == FMT_SHORT ? WORDS_SHORT :
        frame_format == FMT_THROWAWAY ? WORDS_THROWAWAY : frame_format == FMT_SIX_WORD ? WORDS_SIX_WORD :
        frame_format == FMT_MID_INSTR ? WORDS_MID_INSTR : frame_format == FMT_BUS_FAULT ? WORDS_BUS_FAULT : 6'h3f))
        else $error("frame size wrong");
    vec_addr_a: assert property (fetch_req |-> vector_addr == vector_base_pointer + {22'h0, vector_num, 2'b00})
        else $error("vector address wrong");
    new_pc_a: assert property (fetch_req && fetch_done |=> new_pc == $past(fetch_data) && !fetch_req ##[0:1] resume)
        else $error("new pc wrong");
    cover property (iack_req && iack_done);
    cover property (stack_req && stack_short_master);
    cover property (coproc_ack);
endmodule

// ===== cpu_exception_sequencer_tb.sv
// Self-checking bench for the exception sequencer
`timescale 1ns/1ps
module cpu_exception_sequencer_tb;
    import exc_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic        reset_req, bus_err, addr_err, odd_fetch, illegal_instr, priv_instr, breakpoint;
    logic        trace_pend, instr_exc, coproc_exc, coproc_priv_chk, mid_instr;
    logic [2:0]  irq_level;
    instr_src_t  instr_src;
    logic [3:0]  sw_trap_num;
    logic [7:0]  coproc_vector, iack_vector, vector_num;
    logic [15:0] sr_in, sr_out, sr_saved;
    logic [31:0] vector_base_pointer, fetch_data, vector_addr, new_pc, rng = 32'd47774;
    logic        iack_done, stack_done, fetch_done, busy, iack_req, coproc_ack, stack_req;
    logic        stack_master, stack_short_master, fetch_req, resume, external_cause;
    logic [2:0]  iack_level;
    logic [3:0]  frame_format;
    logic [5:0]  frame_words;
    logic [1:0]  dly;
    logic        saw_iack, saw_short, saw_ack, saw_stk;
    logic [4:0]  seen_frm;
    int          bad_count = 0, check_count = 0, cycles = 0;

    cpu_exception_sequencer cpu_exception_sequencer_inst (.*);
    exc_bus_partner exc_bus_partner_inst (.*);

    always #2 mclk = ~mclk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic clear;
        {reset_req, bus_err, addr_err, odd_fetch, illegal_instr, priv_instr, breakpoint} = 7'h00;
        {trace_pend, instr_exc, coproc_exc, coproc_priv_chk} = 4'h0;
        irq_level = 3'h0;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (iack_req) saw_iack = 1'b1;
        if (stack_req) saw_stk = 1'b1;
        if (stack_req && stack_short_master) saw_short = 1'b1;
        if (stack_req && !stack_short_master) seen_frm = {stack_master, frame_format};
        if (coproc_ack) saw_ack = 1'b1;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // One exception: causes, expected results from the rules
    // ------------------------------------------------------------
    task automatic run(input int k);
        logic [7:0]  ev;
        logic [3:0]  ef;
        logic [15:0] es;
        logic [2:0]  lv;
        logic        take, irq, rst, ext, cp, m;
        int          n;
        @(negedge mclk);
        clear();
        rng = xs(rng);
        {mid_instr, dly, coproc_vector, sw_trap_num, sr_in} = rng[30:0];
        vector_base_pointer = xs(rng);
        {take, irq, rst, ext, cp, lv, ev} = {5'b10000, 3'h0, 8'h00};
        case (k)
            0: {reset_req, bus_err, rst, ext, ev} = {4'hf, VEC_RESET};
            1: {bus_err, addr_err, irq_level, ext, ev} = {5'h1f, 1'b1, VEC_BUS_ERR};
            2: {addr_err, trace_pend, ev} = {2'h3, VEC_ADDR_ERR};
            3: {odd_fetch, ev} = {1'b1, VEC_ADDR_ERR};
            4: {trace_pend, irq_level, ev} = {4'hf, VEC_TRACE};
            5: {irq_level, sr_in[12], sr_in[10:8], irq, ext, lv, ev} = {3'h5, 1'b1, 3'h4, 2'h3, 3'h5, 8'h45};
            6: {irq_level, sr_in[10:8], irq, ext, lv, ev} = {6'h3f, 2'h3, 3'h7, 8'h47};
            7: {irq_level, sr_in[10:8], take} = {6'h1b, 1'b0};
            8: {coproc_exc, priv_instr, cp, ev} = {3'h7, coproc_vector};
            9: {coproc_priv_chk, sr_in[13], illegal_instr, ev} = {3'h5, VEC_PRIVILEGE};
            10: {coproc_priv_chk, sr_in[13], take} = 3'h6;
            11: {priv_instr, illegal_instr, ev} = {2'h3, VEC_PRIVILEGE};
            12: {illegal_instr, instr_exc, ev} = {2'h3, VEC_ILLEGAL};
            13: {breakpoint, ev} = {1'b1, VEC_BREAKPOINT};
            default: begin
                {instr_exc, breakpoint} = 2'h3;
                instr_src = instr_src_t'(k - 14);
                ev = (k == 14) ? VEC_SW_BASE + 8'(sw_trap_num) : (k < 18) ? VEC_CONDTRAP :
                    (k < 20) ? VEC_BOUNDS : VEC_DIVIDE;
            end
        endcase
        m = sr_in[12];
        ef = (k >= 1 && k <= 3) ? FMT_BUS_FAULT : (k == 4 || k == 8 || k > 13) ?
            (mid_instr ? FMT_MID_INSTR : FMT_SIX_WORD) : FMT_SHORT;
        {saw_iack, saw_short, saw_ack, saw_stk, seen_frm} = 9'h01f;
        @(negedge mclk);
        check(busy, take);
        clear();
        n = 0;
        while (take && resume !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (take) begin
            es = (sr_in & 16'h1700) | 16'h2000;
            if (irq | rst) es[12] = 1'b0;
            if (irq) es[10:8] = lv;
            if (rst) es[10:8] = IPL_RESET_MASK;
            check(resume, 1'b1);
            check(vector_num, ev);
            check(sr_saved, sr_in);
            check(sr_out & 16'hf700, es);
            check(vector_addr, vector_base_pointer + {ev, 2'b00});
            check(new_pc, (vector_base_pointer + {ev, 2'b00}) ^ 32'h5a5a0000);
            check(external_cause, ext);
            check({saw_iack, saw_short, saw_ack, saw_stk}, {irq, irq & m, cp, !rst});
            if (!rst) check(seen_frm, {m & !irq, ef});
        end
        $display("test %0d done", k);
    endtask

    initial begin
        clear();
        {mid_instr, dly, coproc_vector, sw_trap_num, sr_in, vector_base_pointer} = 63'h0;
        instr_src = INS_SW_TRAP;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 21; k++) run(k);
        end
        give_verdict();
    end
endmodule

bind cpu_exception_sequencer cpu_exception_sequencer_assertions cpu_exception_sequencer_assertions_inst (.*);

// ===== exc_bus_partner.sv
// Far side model: acknowledge cycle, frame write and vector read
`timescale 1ns/1ps
module exc_bus_partner (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  dly,
    input  wire logic        iack_req,
    input  wire logic [2:0]  iack_level,
    input  wire logic        stack_req,
    input  wire logic        fetch_req,
    input  wire logic [31:0] vector_addr,
    output logic             iack_done,
    output logic [7:0]       iack_vector,
    output logic             stack_done,
    output logic             fetch_done,
    output logic [31:0]      fetch_data
);
    logic [1:0] wait_ff;
    logic       req;
    logic       go;
    assign req = (iack_req | stack_req | fetch_req) & ~(iack_done | stack_done | fetch_done);
    assign go  = req && wait_ff == dly;
    // Answers after a variable wait; data lines toggle when not answering
    always_ff @(posedge mclk) begin
        wait_ff     <= (!rst_n || go || !req) ? 2'h0 : wait_ff + 2'h1;
        iack_done   <= rst_n && go && iack_req;
        stack_done  <= rst_n && go && stack_req;
        fetch_done  <= rst_n && go && fetch_req;
        iack_vector <= !rst_n ? 8'h00 : (go && iack_req) ? {5'h08, iack_level} : ~iack_vector;
        fetch_data  <= !rst_n ? 32'h0 : (go && fetch_req) ? vector_addr ^ 32'h5a5a0000 : ~fetch_data;
    end
endmodule

// ===== exc_frame.sv
// Stack frame format and size selection
`timescale 1ns/1ps
module exc_frame (
    input  exc_pkg::exc_class_t         cls,
    input  wire logic                   mid_instr,
    output logic [3:0]                  fmt,
    output logic [5:0]                  words
);
    import exc_pkg::*;

    always_comb begin
        case (cls)
            EXC_BUS_ERR, EXC_ADDR_ERR: begin
                fmt   = FMT_BUS_FAULT;
                words = WORDS_BUS_FAULT;
            end
            EXC_INSTR, EXC_TRACE, EXC_COPROC: begin
                fmt   = mid_instr ? FMT_MID_INSTR : FMT_SIX_WORD;
                words = mid_instr ? WORDS_MID_INSTR : WORDS_SIX_WORD;
            end
            default: begin
                fmt   = FMT_SHORT;
                words = WORDS_SHORT;
            end
        endcase
    end
endmodule

// ===== exc_pkg.sv
// Package of constants and types for the exception sequencer
package exc_pkg;

    // Status register field positions
    localparam int SR_TRACE_HI_BIT  = 15;
    localparam int SR_TRACE_LO_BIT  = 14;
    localparam int SR_SUPER_BIT     = 13;
    localparam int SR_MASTER_BIT    = 12;
    localparam int SR_IPL_LSB       = 8;
    localparam logic [15:0] SR_RESET_VALUE = 16'h2700;
    localparam logic [2:0]  IPL_RESET_MASK = 3'h7;

    // Internally supplied vector numbers
    localparam logic [7:0] VEC_RESET      = 8'h00;
    localparam logic [7:0] VEC_BUS_ERR    = 8'h02;
    localparam logic [7:0] VEC_ADDR_ERR   = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
    localparam logic [7:0] VEC_DIVIDE     = 8'h05;
    localparam logic [7:0] VEC_BOUNDS     = 8'h06;
    localparam logic [7:0] VEC_CONDTRAP   = 8'h07;
    localparam logic [7:0] VEC_PRIVILEGE  = 8'h08;
    localparam logic [7:0] VEC_TRACE      = 8'h09;
    localparam logic [7:0] VEC_BREAKPOINT = 8'h0c;
    localparam logic [7:0] VEC_SW_BASE    = 8'h20;

    // Vector offset shift (number times four)
    localparam int VEC_SHIFT = 2;

    // Frame format codes and frame sizes in 16-bit words
    localparam logic [3:0] FMT_SHORT     = 4'h0;
    localparam logic [3:0] FMT_THROWAWAY = 4'h1;
    localparam logic [3:0] FMT_SIX_WORD  = 4'h2;
    localparam logic [3:0] FMT_MID_INSTR = 4'h9;
    localparam logic [3:0] FMT_BUS_FAULT = 4'ha;
    localparam logic [5:0] WORDS_SHORT     = 6'h04;
    localparam logic [5:0] WORDS_THROWAWAY = 6'h04;
    localparam logic [5:0] WORDS_SIX_WORD  = 6'h06;
    localparam logic [5:0] WORDS_MID_INSTR = 6'h0a;
    localparam logic [5:0] WORDS_BUS_FAULT = 6'h10;

    // Exception classes, ordered by priority
    typedef enum logic [3:0] {
        EXC_NONE      = 4'h0,
        EXC_RESET     = 4'h1,
        EXC_BUS_ERR   = 4'h2,
        EXC_ADDR_ERR  = 4'h3,
        EXC_TRACE     = 4'h4,
        EXC_INTERRUPT = 4'h5,
        EXC_COPROC    = 4'h6,
        EXC_PRIVILEGE = 4'h7,
        EXC_ILLEGAL   = 4'h8,
        EXC_INSTR     = 4'h9,
        EXC_BREAKPT   = 4'ha
    } exc_class_t;

    // Raising instruction selector
    typedef enum logic [2:0] {
        INS_SW_TRAP   = 3'h0,
        INS_CONDTRAP  = 3'h1,
        INS_OVERFLOW  = 3'h2,
        INS_CP_COND   = 3'h3,
        INS_BOUNDS    = 3'h4,
        INS_RANGE     = 3'h5,
        INS_DIVIDE    = 3'h6
    } instr_src_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_STATUS = 3'h1,
        ST_VECTOR = 3'h2,
        ST_STACK  = 3'h3,
        ST_FETCH  = 3'h4,
        ST_RESUME = 3'h5
    } seq_state_t;

endpackage

// ===== exc_prio.sv
// Fixed-priority selection of pending exception causes
`timescale 1ns/1ps
module exc_prio (
    input  wire logic                   reset_req,
    input  wire logic                   bus_err,
    input  wire logic                   addr_err,
    input  wire logic                   trace_pend,
    input  wire logic                   irq_pend,
    input  wire logic                   coproc_exc,
    input  wire logic                   priv_viol,
    input  wire logic                   illegal,
    input  wire logic                   instr_exc,
    input  wire logic                   breakpoint,
    output exc_pkg::exc_class_t         winner
);
    import exc_pkg::*;

    always_comb begin
        if (reset_req) begin
            winner = EXC_RESET;
        end else if (bus_err) begin
            winner = EXC_BUS_ERR;
        end else if (addr_err) begin
            winner = EXC_ADDR_ERR;
        end else if (trace_pend) begin
            winner = EXC_TRACE;
        end else if (irq_pend) begin
            winner = EXC_INTERRUPT;
        end else if (coproc_exc) begin
            winner = EXC_COPROC;
        end else if (priv_viol) begin
            winner = EXC_PRIVILEGE;
        end else if (illegal) begin
            winner = EXC_ILLEGAL;
        end else if (instr_exc) begin
            winner = EXC_INSTR;
        end else if (breakpoint) begin
            winner = EXC_BREAKPT;
        end else begin
            winner = EXC_NONE;
        end
    end
endmodule
